// File: src/sdl_consts.vh
// Constants of the eight-stage serial delay line.
// Included by every design file of the block; definitions only.
`ifndef SDL_CONSTS_VH
`define SDL_CONSTS_VH

// -----------------------------------------------------------------
// Chain geometry
// -----------------------------------------------------------------
`define SDL_STAGES        8
`define SDL_FILL_W        4
`define SDL_FILL_FULL     4'h8
`define SDL_FILL_RST      4'h0
`define SDL_CHAIN_RST     8'h00

// -----------------------------------------------------------------
// Output buffer geometry
// -----------------------------------------------------------------
`define SDL_BUF_WIDTH     1
`define SDL_BUF_DEPTH     8
`define SDL_BUF_PTR_W     3
`define SDL_BUF_CNT_W     4

`endif

// File: src/sdl_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "sdl_consts.vh"

module sdl_fifo #(
   parameter WIDTH = `SDL_BUF_WIDTH,
   parameter DEPTH = `SDL_BUF_DEPTH,
   parameter PTR_W = `SDL_BUF_PTR_W,
   parameter CNT_W = `SDL_BUF_CNT_W
)
(
   input  wire             clk_i,
   input  wire             srst_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);

   // ----------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------
   reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg  [PTR_W-1:0] wr_ptr_q;
   reg  [PTR_W-1:0] rd_ptr_q;
   reg  [CNT_W-1:0] count_q;
   wire             push;
   wire             pop;

   assign in_ready_o  = (count_q != DEPTH[CNT_W-1:0]);
   assign out_valid_o = (count_q != {CNT_W{1'b0}});
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_q <= {PTR_W{1'b0}};
         rd_ptr_q <= {PTR_W{1'b0}};
         count_q  <= {CNT_W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= wr_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rd_ptr_q <= rd_ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
         end
         case ({push, pop})
            2'b10:   count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
            2'b01:   count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
            default: count_q <= count_q;
         endcase
      end
   end

endmodule // sdl_fifo

`default_nettype wire

// File: src/sdl_delay_line.v
// Eight-stage serial-in serial-out delay line with a tap buffer.
// Assumes inputs synchronous to clk_i and a synchronous reset.
//
// Function
// - Eight stages chained, enter first, leave last
// - First stage loads AND of both inputs
// - Each rising edge shifts every stage onward
// - One common clock advances all stages
// - Last stage drives true output; complement comes from its own register loaded with the inverse of the last stage's next value
// - Output equals ANDed input eight edges later
`timescale 1ns/1ps
`default_nettype none
`include "sdl_consts.vh"

module sdl_delay_line
(
   input  wire  clk_i,
   input  wire  srst_i,
   input  wire  data_a_i,
   input  wire  data_b_i,
   output wire  data_true_o,
   output wire  data_comp_o,
   output wire  chain_primed_o,
   output wire  buf_ready_o,
   output wire  buf_overflow_o,
   output wire  tap_valid_o,
   input  wire  tap_ready_i,
   output wire  tap_data_o
);

   // ----------------------------------------------------------------
   // Entry gate
   // ----------------------------------------------------------------
   wire entry_bit;

   assign entry_bit = data_a_i & data_b_i;

   // ----------------------------------------------------------------
   // Stage next values
   // ----------------------------------------------------------------
   reg  [`SDL_STAGES-1:0] stage_q;
   wire [`SDL_STAGES-1:0] stage_d;

   genvar g;
   generate
      for (g = 0; g < `SDL_STAGES; g = g + 1)
      begin : g_stage
         if (g == 0)
         begin : g_first
            assign stage_d[g] = entry_bit;
         end
         else
         begin : g_rest
            assign stage_d[g] = stage_q[g-1];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Stage registers
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         stage_q <= `SDL_CHAIN_RST;
      end
      else
      begin
         stage_q <= stage_d;
      end
   end

   // ----------------------------------------------------------------
   // Complement output
   // ----------------------------------------------------------------
   reg  comp_q;
   wire comp_d;

   assign comp_d = ~stage_d[`SDL_STAGES-1];

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         comp_q <= 1'b1;
      end
      else
      begin
         comp_q <= comp_d;
      end
   end

   // ----------------------------------------------------------------
   // Fill state machine
   // ----------------------------------------------------------------
   localparam [1:0] ST_FILL   = 2'b01;
   localparam [1:0] ST_PRIMED = 2'b10;

   reg  [1:0]             fill_st_q;
   reg  [1:0]             fill_st_d;
   reg  [`SDL_FILL_W-1:0] fill_q;
   reg  [`SDL_FILL_W-1:0] fill_d;
   reg                    primed_q;
   reg                    primed_d;
   wire                   fill_last;

   assign fill_last = (fill_q == (`SDL_FILL_FULL - 4'h1));

   always @*
   begin
      fill_st_d = fill_st_q;
      fill_d    = fill_q;
      primed_d  = primed_q;
      case (fill_st_q)
         ST_FILL:
         begin
            fill_d   = fill_q + 4'h1;
            primed_d = 1'b0;
            if (fill_last)
            begin
               fill_st_d = ST_PRIMED;
               primed_d  = 1'b1;
            end
         end
         ST_PRIMED:
         begin
            fill_d   = `SDL_FILL_FULL;
            primed_d = 1'b1;
         end
         default:
         begin
            fill_st_d = ST_FILL;
            fill_d    = `SDL_FILL_RST;
            primed_d  = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Fill registers
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         fill_st_q <= ST_FILL;
         fill_q    <= `SDL_FILL_RST;
         primed_q  <= 1'b0;
      end
      else
      begin
         fill_st_q <= fill_st_d;
         fill_q    <= fill_d;
         primed_q  <= primed_d;
      end
   end

   // ----------------------------------------------------------------
   // Tap buffer storage
   // ----------------------------------------------------------------
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_data;
   wire fifo_pop;
   wire tap_free;
   reg  tap_valid_q;

   assign tap_free = ~tap_valid_q | tap_ready_i;
   assign fifo_pop = fifo_out_valid & tap_free;

   sdl_fifo #(
      .WIDTH (`SDL_BUF_WIDTH),
      .DEPTH (`SDL_BUF_DEPTH),
      .PTR_W (`SDL_BUF_PTR_W),
      .CNT_W (`SDL_BUF_CNT_W)
   )
   u_fifo
   (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (primed_q),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (stage_q[`SDL_STAGES-1]),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // ----------------------------------------------------------------
   // Tap output stage
   // ----------------------------------------------------------------
   localparam [1:0] TAP_EMPTY = 2'b01;
   localparam [1:0] TAP_HELD  = 2'b10;

   reg  [1:0] tap_st_q;
   reg  [1:0] tap_st_d;
   reg        tap_valid_d;
   reg        tap_data_q;
   reg        tap_data_d;

   always @*
   begin
      tap_st_d   = tap_st_q;
      tap_data_d = tap_data_q;
      case (tap_st_q)
         TAP_EMPTY:
         begin
            if (fifo_pop)
            begin
               tap_st_d   = TAP_HELD;
               tap_data_d = fifo_out_data;
            end
         end
         TAP_HELD:
         begin
            if (fifo_pop)
            begin
               tap_data_d = fifo_out_data;
            end
            else if (tap_ready_i)
            begin
               tap_st_d = TAP_EMPTY;
            end
         end
         default:
         begin
            tap_st_d = TAP_EMPTY;
         end
      endcase
      tap_valid_d = (tap_st_d == TAP_HELD);
   end

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         tap_st_q    <= TAP_EMPTY;
         tap_valid_q <= 1'b0;
         tap_data_q  <= 1'b0;
      end
      else
      begin
         tap_st_q    <= tap_st_d;
         tap_valid_q <= tap_valid_d;
         tap_data_q  <= tap_data_d;
      end
   end

   // ----------------------------------------------------------------
   // Buffer ready
   // ----------------------------------------------------------------
   reg  buf_ready_q;
   reg  buf_ready_d;

   always @*
   begin
      buf_ready_d = fifo_in_ready;
   end

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         buf_ready_q <= 1'b1;
      end
      else
      begin
         buf_ready_q <= buf_ready_d;
      end
   end

   // ----------------------------------------------------------------
   // Overflow flag
   // ----------------------------------------------------------------
   wire drop_bit;
   reg  overflow_q;
   reg  overflow_d;

   assign drop_bit = primed_q & ~fifo_in_ready;

   always @*
   begin
      overflow_d = overflow_q | drop_bit;
   end

   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         overflow_q <= 1'b0;
      end
      else
      begin
         overflow_q <= overflow_d;
      end
   end

   // ----------------------------------------------------------------
   // Output ports
   // ----------------------------------------------------------------
   assign data_true_o    = stage_q[`SDL_STAGES-1];
   assign data_comp_o    = comp_q;
   assign chain_primed_o = primed_q;
   assign tap_valid_o    = tap_valid_q;
   assign tap_data_o     = tap_data_q;
   assign buf_ready_o    = buf_ready_q;
   assign buf_overflow_o = overflow_q;

endmodule // sdl_delay_line

`default_nettype wire

// File: tb/sdl_delay_line_properties.sv
// Checker on the delay line ports.
// Assumes it is bound to sdl_delay_line.
`timescale 1ns/1ps
`default_nettype none
module sdl_chk
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic data_a_i,
   input wire logic data_b_i,
   input wire logic data_true_o,
   input wire logic data_comp_o,
   input wire logic chain_primed_o,
   input wire logic buf_ready_o,
   input wire logic buf_overflow_o,
   input wire logic tap_valid_o,
   input wire logic tap_ready_i,
   input wire logic tap_data_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   property p_dly;
      chain_primed_o |-> data_true_o == $past(data_a_i & data_b_i, 8);
   endproperty
   a_dly: assert property (p_dly) else $error("late bit");
   property p_zero;
      chain_primed_o && !$past(data_b_i, 8) |-> !data_true_o;
   endproperty
   a_zero: assert property (p_zero) else $error("and broken");
   property p_zero_a;
      chain_primed_o && !$past(data_a_i, 8) |-> !data_true_o;
   endproperty
   a_zero_a: assert property (p_zero_a) else $error("and broken on a");
   property p_comp;
      data_comp_o != data_true_o;
   endproperty
   a_comp: assert property (p_comp) else $error("comp wrong");
   property p_fill;
      $fell(srst_i) |-> !chain_primed_o [*8] ##1 chain_primed_o;
   endproperty
   a_fill: assert property (p_fill) else $error("fill count");
   property p_hold;
      tap_valid_o && !tap_ready_i |=> tap_valid_o && $stable(tap_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("tap not held");
   property p_ovf;
      buf_overflow_o |=> buf_overflow_o;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow dropped");
   property p_vld;
      $rose(tap_valid_o) |-> $past(chain_primed_o, 2);
   endproperty
   a_vld: assert property (p_vld) else $error("early tap");
   c_one: cover property (chain_primed_o && data_true_o);
   c_full: cover property (!buf_ready_o);
   c_ovf: cover property ($rose(buf_overflow_o));
endmodule // sdl_chk
`default_nettype wire

// File: tb/sdl_feed_model.sv
// Far-side logic: feeds both data lines, takes tap words.
// Assumes the bench changes go_i and stall_i after an edge.
`timescale 1ns/1ps
`default_nettype none
module sdl_feed
(
   input  wire logic        clk_i,
   input  wire logic        go_i,
   input  wire logic        stall_i,
   input  wire logic [31:0] pa_i,
   input  wire logic [31:0] pb_i,
   output logic             a_o,
   output logic             b_o,
   output logic             rdy_o
);
   int   k = 0;
   logic g;
   logic s;
   initial {a_o, b_o, rdy_o} = 3'h0;
   always @(posedge clk_i)
   begin
      g = go_i;
      s = stall_i;
      #1;
      a_o = g & pa_i[k];
      b_o = g & pb_i[k];
      rdy_o = !s;
      k = g ? (k + 1) % 32 : 0;
   end
endmodule // sdl_feed
`default_nettype wire

// File: tb/sdl_delay_line_tb_top.sv
// Self-checking bench of the delay line.
// Assumes sdl_feed and sdl_chk compiled before it.
`timescale 1ns/1ps
`default_nettype none
module sdl_delay_line_tb_top;
   logic clk_i = 0, srst_i = 1, go = 0, stall = 0;
   logic a, b, rdy, t, c, pr, br, ov, tv, td;
   int   fails = 0, check_count = 0;
   initial forever #12.5 clk_i = ~clk_i;
   sdl_feed u_sdl_feed (.clk_i, .go_i(go), .stall_i(stall), .pa_i(32'hF0CC_AA5F),
      .pb_i(32'h3C0F_FF96), .a_o(a), .b_o(b), .rdy_o(rdy));
   sdl_delay_line u_sdl_delay_line (.clk_i, .srst_i, .data_a_i(a), .data_b_i(b),
      .data_true_o(t), .data_comp_o(c), .chain_primed_o(pr), .buf_ready_o(br),
      .buf_overflow_o(ov), .tap_valid_o(tv), .tap_ready_i(rdy), .tap_data_o(td));
   task chk(string n, logic e, logic g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s exp %b got %b", n, e, g);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task t_reset;
      @(posedge clk_i); #1;
      srst_i = 1;
      go = 0;
      repeat (2) @(posedge clk_i);
      #1;
      chk("true_rst", 1'b0, t);
      chk("comp_rst", 1'b1, c);
      chk("primed_rst", 1'b0, pr);
      chk("ready_rst", 1'b1, br);
      chk("ovf_rst", 1'b0, ov);
      chk("tvalid_rst", 1'b0, tv);
      chk("tdata_rst", 1'b0, td);
      $display("reset done");
   endtask
   task t_stream;
      int lo;
      int n;
      logic [9:0] h;
      lo = 0;
      h = 10'h000;
      srst_i = 0;
      go = 1;
      for (n = 1; n <= 40; n++)
      begin
         @(negedge clk_i);
         if (pr !== 1'b1) lo++;
         else
         begin
            chk("true", h[7], t);
            chk("comp", ~h[7], c);
         end
         if (n >= 11)
         begin
            chk("tvalid", 1'b1, tv);
            chk("tdata", h[9], td);
         end
         h = {h[8:0], a & b};
      end
      chk("fill", 1'b1, lo == 8);
      $display("stream done");
   endtask
   task t_full;
      int i;
      @(posedge clk_i); #1;
      stall = 1;
      for (i = 0; i < 100 && ov !== 1'b1; i++) @(negedge clk_i);
      if (i == 100) fails++;
      chk("ready", 1'b0, br);
      @(posedge clk_i); #1;
      stall = 0;
      for (i = 0; i < 100 && br !== 1'b1; i++) @(negedge clk_i);
      if (i == 100) fails++;
      chk("sticky", 1'b1, ov);
      $display("buffer done");
   endtask
   initial
   begin
      t_reset;
      t_stream;
      t_full;
      t_reset;
      print_verdict;
   end
endmodule // sdl_delay_line_tb_top
bind sdl_delay_line sdl_chk u_sdl_chk (.clk_i, .srst_i, .data_a_i, .data_b_i,
   .data_true_o, .data_comp_o, .chain_primed_o, .buf_ready_o, .buf_overflow_o,
   .tap_valid_o, .tap_ready_i, .tap_data_o);
`default_nettype wire
